// ---- rtl/pldfe_palette_converter.sv ----
`timescale 1ns/10ps
`include "pldfe_defs.svh"

// What this block does
// - Holds a 256 by 18-bit colour table and feeds three 6-bit converter codes.
// - The 8-bit pixel index picks an entry that is split into red, green and blue fields.
// - A programmable pixel mask alters the index before lookup, taking effect at once.
// - The host reaches the table through a 32-bit APB register port, independent of pixel timing.
// - Pixel index, blanking and border are sampled each edge and show three edges later.
// - A low blanking input forces all-zero converter codes.
// - A low border input substitutes the border colour for the table entry.
// - A low shutdown input disables the converters and holds their codes at zero.
// - After shutdown ends, the converters need several clocks before output is valid.
// - The host loads the write address, writes red, green, blue; then the entry is stored.
// - The address increments after every completed write triplet.
// - Loading the read address fetches that entry and then increments the address.
// - After three component reads the next entry is fetched and the address increments.
// - Loading either address mid-triplet abandons it and restarts from red.
module pldfe_palette_converter #(
    parameter logic [3:0] WAKE_CYCLES = `PLDFE_WAKE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [7:0] i_pixel_index_bits,
    input wire logic i_blank_n,
    input wire logic i_border_n,
    input wire logic i_converter_shutdown_n,
    output logic [5:0] o_red,
    output logic [5:0] o_green,
    output logic [5:0] o_blue,
    output logic o_converter_enable
);
    import pldfe_pkg::*;

    pldfe_state_t st;
    pldfe_state_t next_st;
    logic [17:0] host_rdata;
    logic [17:0] pix_rdata;
    logic [7:0] pix_addr;
    logic access;
    logic done;
    logic busy;
    logic mapped;
    logic [31:0] rd_mux;
    logic [5:0] rd_comp;
    logic conv_next;

    // masked index drives the pixel read port
    assign pix_addr = st.s1_idx & st.mask;

    pldfe_clut #(
        .DEPTH(256),
        .AW(8),
        .DW(18)
    ) u_clut (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_we(st.wr_pend),
        .i_waddr(st.wr_addr),
        .i_wdata(st.wr_data),
        .i_raddr_a(st.addr),
        .o_rdata_a(host_rdata),
        .i_raddr_b(pix_addr),
        .o_rdata_b(pix_rdata)
    );

    // host side decode
    always_comb begin
        access = i_psel && i_penable;
        done = access && st.pready;
        busy = (st.fetch != FETCH_IDLE);
        mapped = (i_paddr == `PLDFE_OFF_WADDR) || (i_paddr == `PLDFE_OFF_COLOUR) ||
                 (i_paddr == `PLDFE_OFF_MASK) || (i_paddr == `PLDFE_OFF_RADDR) ||
                 (i_paddr == `PLDFE_OFF_BORDER) || (i_paddr == `PLDFE_OFF_STATUS);
        case (st.count)
            2'h0: rd_comp = st.cv_r;
            2'h1: rd_comp = st.cv_g;
            default: rd_comp = st.cv_b;
        endcase
        rd_mux = 32'h00000000;
        case (i_paddr)
            `PLDFE_OFF_WADDR: rd_mux[7:0] = st.addr;
            `PLDFE_OFF_RADDR: rd_mux[7:0] = st.addr;
            `PLDFE_OFF_COLOUR: begin
                if (st.rd_mode) begin
                    rd_mux[5:0] = rd_comp;
                end
            end
            `PLDFE_OFF_MASK: rd_mux[7:0] = st.mask;
            `PLDFE_OFF_BORDER: rd_mux[17:0] = st.border;
            `PLDFE_OFF_STATUS: begin
                rd_mux[`PLDFE_ST_ADDR] = st.addr;
                rd_mux[`PLDFE_ST_COUNT] = st.count;
                rd_mux[`PLDFE_ST_RDMODE] = st.rd_mode;
                rd_mux[`PLDFE_ST_BUSY] = busy;
                rd_mux[`PLDFE_ST_READY] = st.conv_en;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.wr_pend = 1'b0;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;

        // answer one cycle into the access phase; colour access waits for fetch
        if (access && !st.pready && !(busy && (i_paddr == `PLDFE_OFF_COLOUR))) begin
            next_st.pready = 1'b1;
            next_st.prdata = rd_mux;
            next_st.pslverr = !mapped;
        end

        // table fetch into the colour value register
        case (st.fetch)
            FETCH_IDLE: next_st.fetch = FETCH_IDLE;
            FETCH_ADDR: next_st.fetch = FETCH_DATA;
            FETCH_DATA: begin
                next_st.cv_r = host_rdata[`PLDFE_RED];
                next_st.cv_g = host_rdata[`PLDFE_GREEN];
                next_st.cv_b = host_rdata[`PLDFE_BLUE];
                next_st.addr = st.addr + 8'h01;
                next_st.fetch = FETCH_IDLE;
            end
            default: next_st.fetch = FETCH_IDLE;
        endcase

        // host writes take effect at the completing edge
        if (done && i_pwrite) begin
            case (i_paddr)
                `PLDFE_OFF_WADDR: begin
                    next_st.addr = i_pwdata[7:0];
                    next_st.count = 2'h0;
                    next_st.rd_mode = 1'b0;
                    next_st.fetch = FETCH_IDLE;
                end
                `PLDFE_OFF_RADDR: begin
                    next_st.addr = i_pwdata[7:0];
                    next_st.count = 2'h0;
                    next_st.rd_mode = 1'b1;
                    next_st.fetch = FETCH_ADDR;
                end
                `PLDFE_OFF_COLOUR: begin
                    if (!st.rd_mode) begin
                        case (st.count)
                            2'h0: begin
                                next_st.cv_r = i_pwdata[5:0];
                                next_st.count = 2'h1;
                            end
                            2'h1: begin
                                next_st.cv_g = i_pwdata[5:0];
                                next_st.count = 2'h2;
                            end
                            default: begin
                                next_st.cv_b = i_pwdata[5:0];
                                next_st.wr_pend = 1'b1;
                                next_st.wr_addr = st.addr;
                                next_st.wr_data = {st.cv_r, st.cv_g, i_pwdata[5:0]};
                                next_st.addr = st.addr + 8'h01;
                                next_st.count = 2'h0;
                            end
                        endcase
                    end
                end
                `PLDFE_OFF_MASK: next_st.mask = i_pwdata[7:0];
                `PLDFE_OFF_BORDER: next_st.border = i_pwdata[17:0];
                default: next_st.mask = st.mask;
            endcase
        end

        // component reads step red, green, blue, then refetch
        if (done && !i_pwrite && (i_paddr == `PLDFE_OFF_COLOUR) && st.rd_mode) begin
            if (st.count == 2'h2) begin
                next_st.count = 2'h0;
                next_st.fetch = FETCH_ADDR;
            end else begin
                next_st.count = st.count + 2'h1;
            end
        end

        // pixel pipeline: sample, lookup, select, drive
        next_st.s1_idx = i_pixel_index_bits;
        next_st.s1_blank_n = i_blank_n;
        next_st.s1_border_n = i_border_n;
        next_st.s2_blank_n = st.s1_blank_n;
        next_st.s2_border_n = st.s1_border_n;
        if (!st.s2_blank_n) begin
            next_st.s3_rgb = 18'h00000;
        end else if (!st.s2_border_n) begin
            next_st.s3_rgb = st.border;
        end else begin
            next_st.s3_rgb = pix_rdata;
        end

        // converter shutdown and wake-up
        if (!i_converter_shutdown_n) begin
            next_st.warm = WAKE_CYCLES;
        end else if (st.warm != 4'h0) begin
            next_st.warm = st.warm - 4'h1;
        end
        conv_next = i_converter_shutdown_n && (st.warm == 4'h0);
        next_st.conv_en = conv_next;
        next_st.red = conv_next ? st.s3_rgb[`PLDFE_RED] : 6'h00;
        next_st.green = conv_next ? st.s3_rgb[`PLDFE_GREEN] : 6'h00;
        next_st.blue = conv_next ? st.s3_rgb[`PLDFE_BLUE] : 6'h00;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
            st.fetch <= FETCH_IDLE;
            st.mask <= `PLDFE_MASK_RST;
            st.border <= `PLDFE_BORDER_RST;
            st.s1_blank_n <= 1'b1;
            st.s1_border_n <= 1'b1;
            st.s2_blank_n <= 1'b1;
            st.s2_border_n <= 1'b1;
            st.warm <= WAKE_CYCLES;
        end else begin
            st <= next_st;
        end
    end

    assign o_prdata = st.prdata;
    assign o_pready = st.pready;
    assign o_pslverr = st.pslverr;
    assign o_red = st.red;
    assign o_green = st.green;
    assign o_blue = st.blue;
    assign o_converter_enable = st.conv_en;

    // checks
    AST_BLANK_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !i_blank_n |-> ##4 (o_red == 6'h00 && o_green == 6'h00 && o_blue == 6'h00))
        else $error("blanked pixel did not give zero codes");

    AST_BORDER_SEL: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_blank_n && !i_border_n) |-> ##4
        (!o_converter_enable || {o_red, o_green, o_blue} == $past(st.border, 2)))
        else $error("border colour not driven");

    AST_BLANK_WINS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!i_blank_n && !i_border_n) |-> ##4 ({o_red, o_green, o_blue} == 18'h00000))
        else $error("border beat blanking");

    AST_LATENCY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_blank_n && i_border_n) |-> ##4
        (!o_converter_enable || {o_red, o_green, o_blue} == $past(pix_rdata, 2)))
        else $error("pixel latency broken");

    AST_SHUTDOWN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !i_converter_shutdown_n |=> (!o_converter_enable && {o_red, o_green, o_blue} == 18'h0))
        else $error("converters active during shutdown");

    AST_WAKE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(i_converter_shutdown_n) |=> (!o_converter_enable) [*4])
        else $error("converters enabled too soon after shutdown");

    AST_WRITE_INC: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (done && i_pwrite && i_paddr == `PLDFE_OFF_COLOUR && !st.rd_mode && st.count == 2'h2)
        |=> (st.wr_pend && st.wr_addr == $past(st.addr) && st.addr == $past(st.addr) + 8'h01
             && st.count == 2'h0 && st.wr_data[5:0] == $past(i_pwdata[5:0])))
        else $error("write triplet not stored or address not incremented");

    AST_READ_LOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (done && i_pwrite && i_paddr == `PLDFE_OFF_RADDR) ##1 (st.fetch == FETCH_ADDR)
        ##1 (st.fetch == FETCH_DATA) |=> (st.fetch == FETCH_IDLE &&
        st.addr == $past(i_pwdata[7:0], 3) + 8'h01))
        else $error("read address load did not fetch and increment");

    AST_READ_THIRD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (done && !i_pwrite && i_paddr == `PLDFE_OFF_COLOUR && st.rd_mode && st.count == 2'h2)
        |=> (st.fetch == FETCH_ADDR && st.count == 2'h0))
        else $error("third component read did not refetch");

    AST_ABANDON: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (done && i_pwrite && (i_paddr == `PLDFE_OFF_WADDR || i_paddr == `PLDFE_OFF_RADDR))
        |=> (st.count == 2'h0 && st.addr == $past(i_pwdata[7:0])))
        else $error("address load did not restart the sequence");

    AST_BYTE_UPPER: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_pready && i_paddr == `PLDFE_OFF_COLOUR) |-> (o_prdata[31:6] == 26'h0))
        else $error("colour read has upper bits set");

    AST_MASK: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        1'b1 |=> (pix_addr == ($past(i_pixel_index_bits) & st.mask)))
        else $error("pixel mask not applied");
endmodule

// ---- include/pldfe_defs.svh ----
`ifndef PLDFE_DEFS_SVH
`define PLDFE_DEFS_SVH

// apb byte offsets
`define PLDFE_OFF_WADDR 8'h00
`define PLDFE_OFF_COLOUR 8'h04
`define PLDFE_OFF_MASK 8'h08
`define PLDFE_OFF_RADDR 8'h0c
`define PLDFE_OFF_BORDER 8'h10
`define PLDFE_OFF_STATUS 8'h14

// table word fields
`define PLDFE_RED 17:12
`define PLDFE_GREEN 11:6
`define PLDFE_BLUE 5:0

// status fields
`define PLDFE_ST_ADDR 7:0
`define PLDFE_ST_COUNT 9:8
`define PLDFE_ST_RDMODE 10
`define PLDFE_ST_BUSY 11
`define PLDFE_ST_READY 12

// reset values
`define PLDFE_MASK_RST 8'hff
`define PLDFE_BORDER_RST 18'h00000

// converter wake-up after shutdown, pixel clocks
`define PLDFE_WAKE_CYCLES 4'h8

`endif

// ---- include/pldfe_pkg.sv ----
package pldfe_pkg;

    typedef enum logic [2:0] {
        FETCH_IDLE = 3'b001,
        FETCH_ADDR = 3'b010,
        FETCH_DATA = 3'b100
    } pldfe_fetch_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [1:0] count;
        logic rd_mode;
        pldfe_fetch_t fetch;
        logic [5:0] cv_r;
        logic [5:0] cv_g;
        logic [5:0] cv_b;
        logic [7:0] mask;
        logic [17:0] border;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [17:0] wr_data;
        logic [7:0] s1_idx;
        logic s1_blank_n;
        logic s1_border_n;
        logic s2_blank_n;
        logic s2_border_n;
        logic [17:0] s3_rgb;
        logic [3:0] warm;
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
        logic conv_en;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pldfe_state_t;

endpackage

// ---- rtl/pldfe_clut.sv ----
`timescale 1ns/10ps
module pldfe_clut #(
    parameter int DEPTH = 256,
    parameter int AW = 8,
    parameter int DW = 18
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr_a,
    output logic [DW-1:0] o_rdata_a,
    input wire logic [AW-1:0] i_raddr_b,
    output logic [DW-1:0] o_rdata_b
);
    typedef struct packed {
        logic [DW-1:0] rdata_a;
        logic [DW-1:0] rdata_b;
    } pldfe_clut_state_t;

    logic [DW-1:0] mem [DEPTH];
    pldfe_clut_state_t st;
    pldfe_clut_state_t next_st;

    // table storage, written from the host side
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // two registered read ports: host fetch and pixel lookup
    always_comb begin
        next_st = st;
        next_st.rdata_a = mem[i_raddr_a];
        next_st.rdata_b = mem[i_raddr_b];
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata_a = st.rdata_a;
    assign o_rdata_b = st.rdata_b;
endmodule

// ---- test/pldfe_pixel_source.sv ----
`timescale 1ns/10ps
module pldfe_pixel_source (
    input wire logic i_clk,
    input wire logic i_converter_enable,
    output logic [7:0] o_pixel_index_bits,
    output logic o_blank_n,
    output logic o_border_n,
    output logic o_converter_shutdown_n
);
    // starts blanked so the codes begin at a known zero
    initial begin
        o_pixel_index_bits = 8'h00;
        o_blank_n = 1'b0;
        o_border_n = 1'b1;
        o_converter_shutdown_n = 1'b1;
    end

    // new pixel just after an edge, held for the whole cycle
    task automatic drive(input logic [7:0] idx, input logic bl_n, input logic bo_n,
                         input logic sh_n);
        @(posedge i_clk);
        o_pixel_index_bits <= idx;
        o_blank_n <= bl_n;
        o_border_n <= bo_n;
        o_converter_shutdown_n <= sh_n;
    endtask

    // no reliance on the codes until the converters report ready
    task automatic await_wake(output logic ok);
        int n;
        n = 0;
        while (i_converter_enable !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        ok = (n < 100);
    endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`include "pldfe_defs.svh"
module testbench;
    import pldfe_pkg::*;
    localparam logic [17:0] ENT_A = {6'h05, 6'h3f, 6'h00};
    localparam logic [17:0] ENT_B = {6'h11, 6'h22, 6'h33};
    localparam logic [17:0] ENT_C = {6'h0a, 6'h0b, 6'h0c};
    localparam logic [17:0] BRD = {6'h2a, 6'h15, 6'h0c};
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_converter_enable, ok;
    logic [7:0] pix_idx;
    logic blank_n, border_n, shut_n;
    logic [5:0] o_red, o_green, o_blue;
    logic [17:0] rgb, last;
    logic [31:0] rd;
    logic err;
    logic [7:0] wbytes [6] = '{8'hc5, 8'h7f, 8'h80, 8'h11, 8'h22, 8'h33};
    logic [7:0] rbytes [6] = '{8'h05, 8'h3f, 8'h00, 8'h11, 8'h22, 8'h33};
    int n_errors = 0;
    int num_checks = 0;
    assign rgb = {o_red, o_green, o_blue};
    always #5 i_clk = ~i_clk;

    pldfe_palette_converter #(.WAKE_CYCLES(4'h4)) u_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pixel_index_bits(pix_idx),
        .i_blank_n(blank_n), .i_border_n(border_n), .i_converter_shutdown_n(shut_n),
        .o_red(o_red), .o_green(o_green), .o_blue(o_blue),
        .o_converter_enable(o_converter_enable));

    pldfe_pixel_source u_src (
        .i_clk(i_clk), .i_converter_enable(o_converter_enable),
        .o_pixel_index_bits(pix_idx), .o_blank_n(blank_n), .o_border_n(border_n),
        .o_converter_shutdown_n(shut_n));

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_pix(input string name, input logic [17:0] exp, input logic [17:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_errors++;
            $display("FAIL pready expected 1 seen timeout");
        end
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, rd, err);
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        chk_reg(name, exp, rd);
    endtask

    // fetch busy bit is timing dependent, so it is masked
    task automatic stat(input logic [31:0] exp);
        apb(1'b0, `PLDFE_OFF_STATUS, 32'h0, rd, err);
        chk_reg("status", exp, rd & 32'hfffff7ff);
    endtask

    // change at edge e0, old code through e3, new code at e4
    task automatic pix(input string name, input logic [7:0] idx, input logic bl_n,
                       input logic bo_n, input logic [17:0] exp);
        u_src.drive(idx, bl_n, bo_n, 1'b1);
        repeat (3) @(posedge i_clk);
        #1;
        chk_pix({name, " early"}, last, rgb);
        @(posedge i_clk);
        #1;
        chk_pix(name, exp, rgb);
        last = exp;
    endtask

    initial begin
        #200000;
        n_errors++;
        $display("FAIL watchdog expected done seen timeout");
        tally_and_finish();
    end

    initial begin
        last = 18'h0;
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rdc("mask rst", `PLDFE_OFF_MASK, 32'h000000ff);
        rdc("border rst", `PLDFE_OFF_BORDER, 32'h0);
        $display("test reset done");
        wr(`PLDFE_OFF_WADDR, 8'hfe);
        for (int i = 0; i < 6; i++) wr(`PLDFE_OFF_COLOUR, wbytes[i]);
        stat(32'h00001000);
        wr(`PLDFE_OFF_WADDR, 8'h10);
        wr(`PLDFE_OFF_COLOUR, 8'h01);
        wr(`PLDFE_OFF_COLOUR, 8'h02);
        wr(`PLDFE_OFF_WADDR, 8'h20);
        wr(`PLDFE_OFF_COLOUR, 8'h0a);
        wr(`PLDFE_OFF_COLOUR, 8'h0b);
        stat(32'h00001220);
        wr(`PLDFE_OFF_COLOUR, 8'h0c);
        stat(32'h00001021);
        rdc("wmode read", `PLDFE_OFF_COLOUR, 32'h0);
        $display("test write done");
        wr(`PLDFE_OFF_RADDR, 8'hfe);
        for (int i = 0; i < 6; i++) rdc("colour", `PLDFE_OFF_COLOUR, {24'h0, rbytes[i]});
        stat(32'h00001401);
        wr(`PLDFE_OFF_RADDR, 8'hfe);
        rdc("red", `PLDFE_OFF_COLOUR, 32'h05);
        wr(`PLDFE_OFF_RADDR, 8'h20);
        rdc("red 20", `PLDFE_OFF_COLOUR, 32'h0a);
        rdc("green 20", `PLDFE_OFF_COLOUR, 32'h0b);
        rdc("blue 20", `PLDFE_OFF_COLOUR, 32'h0c);
        apb(1'b0, 8'h18, 32'h0, rd, err);
        chk_reg("unmapped err", 32'h1, {31'h0, err});
        chk_reg("unmapped data", 32'h0, rd);
        $display("test read done");
        u_src.await_wake(ok);
        chk_reg("wake", 32'h1, {31'h0, ok});
        pix("pix fe", 8'hfe, 1'b1, 1'b1, ENT_A);
        pix("pix ff", 8'hff, 1'b1, 1'b1, ENT_B);
        wr(`PLDFE_OFF_MASK, 8'hfe);
        repeat (4) @(posedge i_clk);
        #1;
        chk_pix("mask now", ENT_A, rgb);
        last = ENT_A;
        pix("mask and", 8'h21, 1'b1, 1'b1, ENT_C);
        apb(1'b1, `PLDFE_OFF_BORDER, {14'h0, BRD}, rd, err);
        pix("border", 8'h21, 1'b1, 1'b0, BRD);
        pix("blank", 8'h21, 1'b0, 1'b0, 18'h0);
        pix("resume", 8'hfe, 1'b1, 1'b1, ENT_A);
        u_src.drive(8'hfe, 1'b1, 1'b1, 1'b0);
        repeat (2) @(posedge i_clk);
        #1;
        chk_pix("off codes", 18'h0, rgb);
        chk_reg("off enable", 32'h0, {31'h0, o_converter_enable});
        u_src.drive(8'hfe, 1'b1, 1'b1, 1'b1);
        #1;
        chk_reg("warm enable", 32'h0, {31'h0, o_converter_enable});
        u_src.await_wake(ok);
        repeat (4) @(posedge i_clk);
        #1;
        chk_reg("woke", 32'h1, {31'h0, ok & o_converter_enable});
        chk_pix("woke codes", ENT_A, rgb);
        $display("test pixel done");
        tally_and_finish();
    end
endmodule
